/* design/cpc_pkg.sv */
// Purpose: shared constants and types for the codec power and path control block
// Assumes: control instructions arrive already deserialised as one address byte plus data byte
// Notes:   field positions of the codec control registers, timing counts, state type
package cpc_pkg;

  // register indices carried in instruction bits 6:3
  localparam logic [3:0] IDX_FORMAT = 4'h0;
  localparam logic [3:0] IDX_SLOT   = 4'h1;
  localparam logic [3:0] IDX_PATH   = 4'h4;
  localparam logic [3:0] IDX_GAIN   = 4'h5;
  localparam logic [3:0] IDX_ATTEN  = 4'h6;
  localparam logic [3:0] IDX_TONE   = 4'h7;

  // instruction byte layout
  localparam int INS_POWER_BIT   = 7;
  localparam int INS_IDX_LSB     = 3;
  localparam int INS_READ_BIT    = 2;
  localparam int INS_TWO_BYTE_BIT = 1;

  // format_config_register fields
  localparam int FMT_CODING_BIT  = 5;
  localparam int FMT_FORMAT_BIT  = 2;
  // slot_mode_register fields
  localparam int SLOT_SYNC_HI_BIT = 7;
  localparam int SLOT_SYNC_LO_BIT = 6;
  localparam int SLOT_ENABLE_BIT = 2;
  localparam int SLOT_B2_BIT     = 1;
  // path_select_register fields
  localparam int PATH_MIC_LSB    = 6;
  localparam int PATH_EAR_TONE_BIT = 5;
  localparam int PATH_EAR_SIDE_BIT = 4;
  localparam int PATH_EXT_TONE_BIT = 3;
  localparam int PATH_EXT_SIDE_BIT = 2;
  localparam int PATH_EAR_ROUTE_BIT = 1;
  localparam int PATH_EXT_ROUTE_BIT = 0;
  // nibble positions shared by gain, attenuation and tone registers
  localparam int HI_NIB_LSB      = 4;
  localparam int LO_NIB_LSB      = 0;

  // reset values
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_SLOT   = 8'h00;
  localparam logic [7:0] RST_PATH   = 8'h00;
  localparam logic [7:0] RST_GAIN   = 8'h00;
  localparam logic [7:0] RST_ATTEN  = 8'h00;
  localparam logic [7:0] RST_TONE   = 8'h00;

  // microphone select codes
  localparam logic [1:0] MIC_ONE   = 2'h0;
  localparam logic [1:0] MIC_TWO   = 2'h1;
  localparam logic [1:0] MIC_THREE = 2'h2;
  localparam logic [1:0] MIC_MUTE  = 2'h3;

  // frame marker timing codes (high bit set means delayed)
  localparam logic [1:0] SYNC_NORMAL  = 2'h0;
  localparam logic [1:0] SYNC_REVERSE = 2'h1;

  // level steps in tenths of a dB
  localparam logic [4:0] TX_GAIN_STEP = 5'h0f;
  localparam logic [4:0] ATTEN_STEP   = 5'h14;

  // slot geometry in bit periods
  localparam logic [4:0] BITS_COMPANDED = 5'h08;
  localparam logic [4:0] BITS_LINEAR    = 5'h10;
  localparam logic [4:0] B2_GAP_FMT1    = 5'h08;
  localparam logic [4:0] B2_GAP_FMT2    = 5'h0a;

  // frame markers after power-up before transmit may drive
  localparam logic [1:0] FS_HOLDOFF = 2'h2;

  // master clock loss detection
  localparam int CLK_PERIOD_NS = 40;
  localparam int MCLK_LOSS_NS  = 10000;
  localparam logic [8:0] MCLK_LOSS_CYC = 9'(MCLK_LOSS_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {PWR_DOWN, PWR_HOLDOFF, PWR_UP} cpc_pwr_t;

endpackage

/* design/cpc_pcm_if.sv */
// Purpose: carrier between the control core and the serial voice shifter
// Assumes: single clock domain, edges already detected as one-cycle pulses
// Notes:   ctl drives timing and data, shift returns the serial results
`timescale 1ns/10ps
interface cpc_pcm_if;
  logic        tx_edge;
  logic        rx_edge;
  logic        slot_start;
  logic [4:0]  nbits;
  logic        tx_allow;
  logic        rx_allow;
  logic [15:0] tx_word;
  logic        rx_bit;
  logic [15:0] rx_word;
  logic        rx_valid;
  logic        tx_bit;
  logic        tx_oe;
  logic        busy;

  modport ctl (output tx_edge, rx_edge, slot_start, nbits, tx_allow, rx_allow, tx_word, rx_bit,
               input  rx_word, rx_valid, tx_bit, tx_oe, busy);
  modport shift (input  tx_edge, rx_edge, slot_start, nbits, tx_allow, rx_allow, tx_word, rx_bit,
                 output rx_word, rx_valid, tx_bit, tx_oe, busy);
endinterface

/* design/cpc_pcm_shift.sv */
// Purpose: voice slot shifter, msb first, transmit and receive in the same slot
// Assumes: tx_edge and rx_edge are already chosen for the sync mode
// Notes:   companded words use bits 15:8 on transmit and 7:0 on receive
`timescale 1ns/10ps
module cpc_pcm_shift (
  input  wire logic    clk,
  input  wire logic    rst_n,
  cpc_pcm_if.shift     pcm
);
  logic        active, next_active;
  logic [15:0] tx_sh, next_tx_sh;
  logic [15:0] rx_sh, next_rx_sh;
  logic [4:0]  rcnt, next_rcnt;
  logic [15:0] rx_word, next_rx_word;
  logic        rx_valid, next_rx_valid;

  always_comb begin
    next_active   = active;
    next_tx_sh    = tx_sh;
    next_rx_sh    = rx_sh;
    next_rcnt     = rcnt;
    next_rx_word  = rx_word;
    next_rx_valid = 1'b0;
    if (pcm.slot_start) begin
      // start wins over a coincident edge so the first bit is not shifted away
      next_active = 1'b1;
      next_tx_sh  = pcm.tx_word;
      next_rcnt   = 5'h00;
    end else if (active) begin
      if (pcm.tx_edge) begin
        next_tx_sh = {tx_sh[14:0], 1'b0};
      end
      if (pcm.rx_edge) begin
        next_rx_sh = {rx_sh[14:0], pcm.rx_bit};
        next_rcnt  = rcnt + 5'h01;
        if (rcnt == pcm.nbits - 5'h01) begin
          next_active = 1'b0;
          next_rx_word = {rx_sh[14:0], pcm.rx_bit};
          next_rx_valid = pcm.rx_allow;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active   <= 1'b0;
      tx_sh    <= 16'h0000;
      rx_sh    <= 16'h0000;
      rcnt     <= 5'h00;
      rx_word  <= 16'h0000;
      rx_valid <= 1'b0;
    end else begin
      active   <= next_active;
      tx_sh    <= next_tx_sh;
      rx_sh    <= next_rx_sh;
      rcnt     <= next_rcnt;
      rx_word  <= next_rx_word;
      rx_valid <= next_rx_valid;
    end
  end

  assign pcm.tx_bit   = tx_sh[15];
  assign pcm.tx_oe    = active & pcm.tx_allow;
  assign pcm.busy     = active;
  assign pcm.rx_word  = rx_word;
  assign pcm.rx_valid = rx_valid;
endmodule

/* design/cpc_path_ctrl.sv */
// Purpose: codec power sequencing, control registers, path and level outputs, voice slot timing
// Assumes: master clock and frame marker sampled on CORE_CLK_IN, instructions pre-decoded
// Notes:   master clock up to 2.56 MHz leaves several core cycles per half period
`timescale 1ns/10ps
module cpc_path_ctrl
  import cpc_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RSTN_IN,
  // control instruction port
  input  wire logic        CTRL_VALID_IN,
  input  wire logic [7:0]  CTRL_ADDR_IN,
  input  wire logic [7:0]  CTRL_DATA_IN,
  output logic [7:0]       CTRL_RDATA_OUT,
  output logic             CTRL_RVALID_OUT,
  // voice serial port
  input  wire logic        MCLK_IN,
  input  wire logic        FRAME_MARKER_IN,
  input  wire logic        PCM_RX_IN,
  output logic             PCM_TX_OUT,
  output logic             PCM_TX_OE_OUT,
  // codec data path
  input  wire logic [15:0] TX_SAMPLE_IN,
  output logic             ENCODE_START_OUT,
  output logic [15:0]      RX_SAMPLE_OUT,
  output logic             RX_SAMPLE_VALID_OUT,
  // power and mode status
  output logic             POWER_UP_OUT,
  output logic             MCLK_LOST_OUT,
  output logic             CODING_MODE_OUT,
  output logic [1:0]       SYNC_MODE_OUT,
  // analog path control
  output logic [2:0]       MIC_ENABLE_OUT,
  output logic             TX_MUTE_OUT,
  output logic [3:0]       TX_GAIN_CODE_OUT,
  output logic [7:0]       TX_GAIN_TENTH_DB_OUT,
  output logic [3:0]       SIDETONE_LEVEL_OUT,
  output logic [3:0]       TONE_LEVEL_OUT,
  output logic [3:0]       EAR_ATTEN_CODE_OUT,
  output logic [8:0]       EAR_ATTEN_TENTH_DB_OUT,
  output logic [3:0]       EXTRA_ATTEN_CODE_OUT,
  output logic [8:0]       EXTRA_ATTEN_TENTH_DB_OUT,
  output logic [2:0]       EAR_SUM_SEL_OUT,
  output logic [2:0]       EXTRA_SUM_SEL_OUT
);

  function automatic logic [8:0] step_scale(input logic [3:0] code, input logic [4:0] step);
    step_scale = 9'(code * step);
  endfunction

  cpc_pcm_if pcm ();

  // control registers
  logic [7:0] format_config_register, next_format;
  logic [7:0] slot_mode_register,     next_slot;
  logic [7:0] path_select_register,   next_path;
  logic [7:0] tx_gain_sidetone_register, next_gain;
  logic [7:0] output_attenuation_register, next_atten;
  logic [7:0] tone_level_register,    next_tone;
  logic [7:0] rdata, next_rdata;
  logic       rvalid, next_rvalid;

  logic       is_two_byte;
  logic       is_read;
  logic [3:0] ins_idx;

  assign is_two_byte = CTRL_ADDR_IN[INS_TWO_BYTE_BIT];
  assign is_read     = CTRL_ADDR_IN[INS_READ_BIT];
  assign ins_idx     = CTRL_ADDR_IN[INS_IDX_LSB +: 4];

  // writes are taken regardless of power state
  always_comb begin
    next_format = format_config_register;
    next_slot   = slot_mode_register;
    next_path   = path_select_register;
    next_gain   = tx_gain_sidetone_register;
    next_atten  = output_attenuation_register;
    next_tone   = tone_level_register;
    next_rdata  = rdata;
    next_rvalid = 1'b0;
    if (CTRL_VALID_IN && is_two_byte && !is_read) begin
      case (ins_idx)
        IDX_FORMAT: next_format = CTRL_DATA_IN;
        IDX_SLOT:   next_slot   = CTRL_DATA_IN;
        IDX_PATH:   next_path   = CTRL_DATA_IN;
        IDX_GAIN:   next_gain   = CTRL_DATA_IN;
        IDX_ATTEN:  next_atten  = CTRL_DATA_IN;
        IDX_TONE:   next_tone   = CTRL_DATA_IN;
        default:    next_rvalid = 1'b0;
      endcase
    end else if (CTRL_VALID_IN && is_two_byte && is_read) begin
      next_rvalid = 1'b1;
      case (ins_idx)
        IDX_FORMAT: next_rdata = format_config_register;
        IDX_SLOT:   next_rdata = slot_mode_register;
        IDX_PATH:   next_rdata = path_select_register;
        IDX_GAIN:   next_rdata = tx_gain_sidetone_register;
        IDX_ATTEN:  next_rdata = output_attenuation_register;
        IDX_TONE:   next_rdata = tone_level_register;
        default:    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      format_config_register      <= RST_FORMAT;
      slot_mode_register          <= RST_SLOT;
      path_select_register        <= RST_PATH;
      tx_gain_sidetone_register   <= RST_GAIN;
      output_attenuation_register <= RST_ATTEN;
      tone_level_register         <= RST_TONE;
      rdata                       <= 8'h00;
      rvalid                      <= 1'b0;
    end else begin
      format_config_register      <= next_format;
      slot_mode_register          <= next_slot;
      path_select_register        <= next_path;
      tx_gain_sidetone_register   <= next_gain;
      output_attenuation_register <= next_atten;
      tone_level_register         <= next_tone;
      rdata                       <= next_rdata;
      rvalid                      <= next_rvalid;
    end
  end

  // pin sampling and edge detection; stage one feeds stage two only
  logic [2:0] mclk_sync;
  logic [2:0] fs_sync;
  logic [8:0] idle_cnt, next_idle_cnt;
  logic       mclk_rise, mclk_fall, fs_rise, mclk_lost;

  assign mclk_rise = mclk_sync[1] & ~mclk_sync[2];
  assign mclk_fall = ~mclk_sync[1] & mclk_sync[2];
  assign fs_rise   = fs_sync[1] & ~fs_sync[2];
  assign mclk_lost = (idle_cnt == MCLK_LOSS_CYC);

  // watchdog saturates so a stopped clock holds the device down
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (mclk_rise || mclk_fall) begin
      next_idle_cnt = 9'h000;
    end else if (!mclk_lost) begin
      next_idle_cnt = idle_cnt + 9'h001;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mclk_sync <= 3'h0;
      fs_sync   <= 3'h0;
      idle_cnt  <= 9'h000;
    end else begin
      mclk_sync <= {mclk_sync[1:0], MCLK_IN};
      fs_sync   <= {fs_sync[1:0], FRAME_MARKER_IN};
      idle_cnt  <= next_idle_cnt;
    end
  end

  // power sequencing
  cpc_pwr_t   pwr, next_pwr;
  logic [1:0] fs_cnt, next_fs_cnt;
  logic       holdoff_done;

  assign holdoff_done = fs_rise && (fs_cnt == FS_HOLDOFF - 2'h1);

  always_comb begin
    next_pwr    = pwr;
    next_fs_cnt = fs_cnt;
    case (pwr)
      PWR_DOWN: begin
        next_fs_cnt = 2'h0;
        if (CTRL_VALID_IN && !CTRL_ADDR_IN[INS_POWER_BIT]) begin
          next_pwr = PWR_HOLDOFF;
        end
      end
      PWR_HOLDOFF: begin
        if (fs_rise) begin
          next_fs_cnt = fs_cnt + 2'h1;
        end
        if (holdoff_done) begin
          next_pwr = PWR_UP;
        end
      end
      PWR_UP: next_fs_cnt = 2'h0;
      default: next_pwr = PWR_DOWN;
    endcase
    if (CTRL_VALID_IN && CTRL_ADDR_IN[INS_POWER_BIT]) begin
      next_pwr = PWR_DOWN;
    end
    if (mclk_lost) begin
      next_pwr = PWR_DOWN;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pwr    <= PWR_DOWN;
      fs_cnt <= 2'h0;
    end else begin
      pwr    <= next_pwr;
      fs_cnt <= next_fs_cnt;
    end
  end

  // slot timing
  logic       coding_companded;
  logic       delayed_mode;
  logic       reverse_mode;
  logic       voice_enable;
  logic       powered;
  logic       tx_edge, rx_edge;
  logic [4:0] slot_offset;
  logic       frame_armed, next_frame_armed;
  logic       frame_begin;
  logic [4:0] skip, next_skip;
  logic       skipping, next_skipping;
  logic       slot_start;

  assign coding_companded = format_config_register[FMT_CODING_BIT];
  assign delayed_mode = slot_mode_register[SLOT_SYNC_HI_BIT];
  assign reverse_mode = !delayed_mode &&
                        (slot_mode_register[SLOT_SYNC_LO_BIT +: 1] == SYNC_REVERSE[0]);
  assign voice_enable = slot_mode_register[SLOT_ENABLE_BIT];
  assign powered      = (pwr != PWR_DOWN);
  assign tx_edge      = reverse_mode ? mclk_fall : mclk_rise;
  assign rx_edge      = reverse_mode ? mclk_rise : mclk_fall;

  // the second slot exists only for companded words
  assign slot_offset = (coding_companded && slot_mode_register[SLOT_B2_BIT]) ?
                       (format_config_register[FMT_FORMAT_BIT] ? B2_GAP_FMT2 : B2_GAP_FMT1) :
                       5'h00;

  // delayed mode starts at the first transmit edge after the marker, others at the marker
  assign frame_begin = delayed_mode ? (frame_armed && tx_edge) : fs_rise;
  assign slot_start  = powered && ((frame_begin && slot_offset == 5'h00) ||
                       (skipping && tx_edge && skip == 5'h01));

  always_comb begin
    next_frame_armed = frame_armed;
    next_skip        = skip;
    next_skipping    = skipping;
    if (fs_rise) begin
      next_frame_armed = delayed_mode;
    end else if (tx_edge) begin
      next_frame_armed = 1'b0;
    end
    if (frame_begin && slot_offset != 5'h00) begin
      next_skipping = 1'b1;
      next_skip     = slot_offset;
    end else if (skipping && tx_edge) begin
      next_skip     = skip - 5'h01;
      next_skipping = (skip != 5'h01);
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      frame_armed <= 1'b0;
      skip        <= 5'h00;
      skipping    <= 1'b0;
    end else begin
      frame_armed <= next_frame_armed;
      skip        <= next_skip;
      skipping    <= next_skipping;
    end
  end

  assign pcm.tx_edge    = tx_edge;
  assign pcm.rx_edge    = rx_edge;
  assign pcm.slot_start = slot_start;
  assign pcm.nbits      = coding_companded ? BITS_COMPANDED : BITS_LINEAR;
  // transmit may drive in the frame that the holdoff-ending marker opens
  assign pcm.tx_allow   = voice_enable && !mclk_lost &&
                          ((pwr == PWR_UP) || (pwr == PWR_HOLDOFF && holdoff_done));
  assign pcm.rx_allow   = voice_enable && powered;
  assign pcm.tx_word    = TX_SAMPLE_IN;
  assign pcm.rx_bit     = PCM_RX_IN;

  cpc_pcm_shift u_shift (
    .clk   (CORE_CLK_IN),
    .rst_n (RSTN_IN),
    .pcm   (pcm)
  );

  // registered level and path outputs
  logic [1:0] mic_code;
  logic       muted;
  logic [2:0] mic_en, next_mic_en;
  logic [7:0] gain_db, next_gain_db;
  logic [8:0] ear_db, next_ear_db;
  logic [8:0] ext_db, next_ext_db;
  logic [2:0] ear_sel, next_ear_sel;
  logic [2:0] ext_sel, next_ext_sel;

  assign mic_code = path_select_register[PATH_MIC_LSB +: 2];
  assign muted    = (mic_code == MIC_MUTE);

  always_comb begin
    case (mic_code)
      MIC_ONE:   next_mic_en = 3'h1;
      MIC_TWO:   next_mic_en = 3'h2;
      MIC_THREE: next_mic_en = 3'h4;
      default:   next_mic_en = 3'h0;
    endcase
    if (!powered) begin
      next_mic_en = 3'h0;
    end
    next_gain_db = 8'(step_scale(tx_gain_sidetone_register[HI_NIB_LSB +: 4],
                                 TX_GAIN_STEP));
    next_ear_db  = step_scale(output_attenuation_register[HI_NIB_LSB +: 4], ATTEN_STEP);
    next_ext_db  = step_scale(output_attenuation_register[LO_NIB_LSB +: 4], ATTEN_STEP);
    // summer selects are {sidetone, tone, speech}
    next_ear_sel = {path_select_register[PATH_EAR_SIDE_BIT] & ~muted,
                    path_select_register[PATH_EAR_TONE_BIT],
                    path_select_register[PATH_EAR_ROUTE_BIT]};
    next_ext_sel = {path_select_register[PATH_EXT_SIDE_BIT] & ~muted,
                    path_select_register[PATH_EXT_TONE_BIT],
                    path_select_register[PATH_EXT_ROUTE_BIT]};
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mic_en  <= 3'h0;
      gain_db <= 8'h00;
      ear_db  <= 9'h000;
      ext_db  <= 9'h000;
      ear_sel <= 3'h0;
      ext_sel <= 3'h0;
    end else begin
      mic_en  <= next_mic_en;
      gain_db <= next_gain_db;
      ear_db  <= next_ear_db;
      ext_db  <= next_ext_db;
      ear_sel <= next_ear_sel;
      ext_sel <= next_ext_sel;
    end
  end

  assign CTRL_RDATA_OUT   = rdata;
  assign CTRL_RVALID_OUT  = rvalid;
  assign PCM_TX_OUT       = pcm.tx_bit & pcm.tx_oe;
  assign PCM_TX_OE_OUT    = pcm.tx_oe;
  assign ENCODE_START_OUT = slot_start;
  assign RX_SAMPLE_OUT    = pcm.rx_word;
  assign RX_SAMPLE_VALID_OUT = pcm.rx_valid;
  assign POWER_UP_OUT     = powered;
  assign MCLK_LOST_OUT    = mclk_lost;
  assign CODING_MODE_OUT  = coding_companded;
  assign SYNC_MODE_OUT    = slot_mode_register[SLOT_SYNC_LO_BIT +: 2];
  assign MIC_ENABLE_OUT   = mic_en;
  assign TX_MUTE_OUT      = muted;
  assign TX_GAIN_CODE_OUT = tx_gain_sidetone_register[HI_NIB_LSB +: 4];
  assign TX_GAIN_TENTH_DB_OUT = gain_db;
  assign SIDETONE_LEVEL_OUT = tx_gain_sidetone_register[LO_NIB_LSB +: 4];
  assign TONE_LEVEL_OUT   = tone_level_register[HI_NIB_LSB +: 4];
  assign EAR_ATTEN_CODE_OUT = output_attenuation_register[HI_NIB_LSB +: 4];
  assign EAR_ATTEN_TENTH_DB_OUT = ear_db;
  assign EXTRA_ATTEN_CODE_OUT = output_attenuation_register[LO_NIB_LSB +: 4];
  assign EXTRA_ATTEN_TENTH_DB_OUT = ext_db;
  assign EAR_SUM_SEL_OUT   = ear_sel;
  assign EXTRA_SUM_SEL_OUT = ext_sel;
endmodule

/* verif/cpc_path_ctrl_assertions.sv */
// Purpose: concurrent checks on the codec power and path control ports
// Assumes: one core clock, asynchronous active-low reset
// Notes:   frame marker rises pass two flops, as in the block's own edge detection
`timescale 1ns/10ps
module cpc_path_ctrl_assertions (
  input wire logic       CORE_CLK_IN,
  input wire logic       RSTN_IN,
  input wire logic       CTRL_VALID_IN,
  input wire logic [7:0] CTRL_ADDR_IN,
  input wire logic       CTRL_RVALID_OUT,
  input wire logic       FRAME_MARKER_IN,
  input wire logic       PCM_TX_OE_OUT,
  input wire logic       ENCODE_START_OUT,
  input wire logic       POWER_UP_OUT,
  input wire logic       MCLK_LOST_OUT,
  input wire logic [2:0] MIC_ENABLE_OUT,
  input wire logic       TX_MUTE_OUT,
  input wire logic [3:0] TX_GAIN_CODE_OUT,
  input wire logic [7:0] TX_GAIN_TENTH_DB_OUT,
  input wire logic [3:0] EAR_ATTEN_CODE_OUT,
  input wire logic [8:0] EAR_ATTEN_TENTH_DB_OUT
);
  logic [2:0] fs_d;
  logic [1:0] fs_count;
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      fs_d     <= 3'h0;
      fs_count <= 2'h0;
    end else begin
      fs_d     <= {fs_d[1:0], FRAME_MARKER_IN};
      // marker rises since power-up, saturating at the second one
      if (!POWER_UP_OUT) begin
        fs_count <= 2'h0;
      end else if (fs_d[2:1] == 2'b01 && fs_count != 2'h2) begin
        fs_count <= fs_count + 2'h1;
      end
    end
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence rd_req;
    CTRL_VALID_IN && CTRL_ADDR_IN[2:1] == 2'b11;
  endsequence
  sequence up_req;
    CTRL_VALID_IN && !CTRL_ADDR_IN[7];
  endsequence
  read_answer_a: assert property (rd_req |=> CTRL_RVALID_OUT)
    else $error("read not answered");
  power_down_a: assert property (CTRL_VALID_IN && CTRL_ADDR_IN[7] |=> !POWER_UP_OUT)
    else $error("power down flag ignored");
  power_up_a: assert property (up_req and !MCLK_LOST_OUT |=> POWER_UP_OUT)
    else $error("power up flag ignored");
  tx_holdoff_a: assert property (PCM_TX_OE_OUT |-> fs_count == 2'h2)
    else $error("transmit driven before second frame marker");
  oe_power_a: assert property (PCM_TX_OE_OUT |-> POWER_UP_OUT)
    else $error("transmit driven while down");
  encode_power_a: assert property (ENCODE_START_OUT |-> POWER_UP_OUT)
    else $error("encode start while down");
  mic_select_a: assert property (MIC_ENABLE_OUT != 3'h0 |->
    $onehot(MIC_ENABLE_OUT) && $past(POWER_UP_OUT) && !$past(TX_MUTE_OUT))
    else $error("microphone enable wrong");
  gain_scale_a: assert property (TX_GAIN_TENTH_DB_OUT ==
    8'($past(TX_GAIN_CODE_OUT)) * 8'h0f)
    else $error("transmit gain scale wrong");
  ear_scale_a: assert property (EAR_ATTEN_TENTH_DB_OUT ==
    9'($past(EAR_ATTEN_CODE_OUT)) * 9'h014)
    else $error("earpiece attenuation scale wrong");
  clock_loss_a: assert property (MCLK_LOST_OUT |=> !POWER_UP_OUT)
    else $error("clock loss did not power down");
endmodule

/* verif/cpc_pcm_partner.sv */
// Purpose: baseband side of the voice port: master clock, frame marker, receive bits
// Assumes: normal frame timing, master clock of ten core cycles, 32 bits a frame
// Notes:   the master clock stands still while run is low
`timescale 1ns/10ps
module cpc_pcm_partner (
  input  wire logic clk,
  input  wire logic run,
  output logic      mclk,
  output logic      fs,
  output logic      rx
);
  localparam logic [7:0] RX_BYTE = 8'ha5;
  logic [2:0] ph = 3'h0;
  logic [4:0] bt = 5'h0;
  initial {mclk, fs, rx} = 3'b000;
  always @(negedge clk) begin
    if (run) begin
      ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h4) begin
        mclk <= !mclk;
        if (!mclk) begin
          bt <= bt + 5'h1;
          fs <= (bt == 5'h1f);
          // change on the rise so the fall sees it settled; outside the slot it toggles
          rx <= (bt == 5'h1f || bt < 5'h07) ? RX_BYTE[3'h6 - bt[2:0]] : !rx;
        end
      end
    end
  end
endmodule

/* verif/cpc_path_ctrl_tb.sv */
// Purpose: directed bench for the codec power and path control block
// Assumes: partner supplies master clock, frame marker and receive bits
// Notes:   companded mode keeps the voice slot to eight bits
`timescale 1ns/10ps
module cpc_path_ctrl_tb;
  import cpc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, run = 1'b0;
  logic [7:0] addr = 8'h00, data = 8'h00, rdata, txb;
  logic rvalid, tx, oe, enc, rxv, pwr, lost, cmode, mute, mclk, fs, rx, mq, fsq, es, rv;
  logic [15:0] rxw, n;
  logic [1:0] sync;
  logic [2:0] mic, ears, exts;
  logic [3:0] gcode, side, tone, ecode, xcode;
  logic [7:0] gdb;
  logic [8:0] edb, xdb;
  logic [7:0] pv[4] = '{8'h3f, 8'h62, 8'h95, 8'hff};
  logic [9:0] pe[4] = '{10'h0bf, 10'h118, 10'h225, 10'h05b};
  int err_count = 0;
  int compares = 0;
  cpc_path_ctrl cpc_path_ctrl_inst (.CORE_CLK_IN(clk), .RSTN_IN(rst_n), .CTRL_VALID_IN(valid),
    .CTRL_ADDR_IN(addr), .CTRL_DATA_IN(data), .CTRL_RDATA_OUT(rdata), .CTRL_RVALID_OUT(rvalid),
    .MCLK_IN(mclk), .FRAME_MARKER_IN(fs), .PCM_RX_IN(rx), .PCM_TX_OUT(tx), .PCM_TX_OE_OUT(oe),
    .TX_SAMPLE_IN(16'h3c00), .ENCODE_START_OUT(enc), .RX_SAMPLE_OUT(rxw),
    .RX_SAMPLE_VALID_OUT(rxv), .POWER_UP_OUT(pwr), .MCLK_LOST_OUT(lost),
    .CODING_MODE_OUT(cmode), .SYNC_MODE_OUT(sync), .MIC_ENABLE_OUT(mic), .TX_MUTE_OUT(mute),
    .TX_GAIN_CODE_OUT(gcode), .TX_GAIN_TENTH_DB_OUT(gdb), .SIDETONE_LEVEL_OUT(side),
    .TONE_LEVEL_OUT(tone), .EAR_ATTEN_CODE_OUT(ecode), .EAR_ATTEN_TENTH_DB_OUT(edb),
    .EXTRA_ATTEN_CODE_OUT(xcode), .EXTRA_ATTEN_TENTH_DB_OUT(xdb), .EAR_SUM_SEL_OUT(ears),
    .EXTRA_SUM_SEL_OUT(exts));
  cpc_pcm_partner cpc_pcm_partner_inst (.clk(clk), .run(run), .mclk(mclk), .fs(fs), .rx(rx));
  always #20 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held from one falling edge to the next, answers settle one edge later
  task automatic send(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {valid, addr, data} = {1'b1, a, d};
    @(negedge clk);
    valid = 1'b0;
    // read-back valid stands for one cycle only, so catch it here
    rv = rvalid;
    @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    {rst_n, run} = 2'b11;
    chk({pwr, oe, mic, cmode}, 16'h0);
    $display("reset test done");
    send({1'b1, IDX_GAIN, 3'b010}, 8'hf3);
    send({1'b1, IDX_ATTEN, 3'b010}, 8'ha5);
    send({1'b1, IDX_TONE, 3'b010}, 8'h70);
    send({1'b1, IDX_FORMAT, 3'b010}, 8'h20);
    chk({gcode, side, tone}, 16'h0f37);
    chk({gdb, ecode, xcode}, 16'he1a5);
    chk({edb, xdb[6:0]}, 16'h6464);
    chk(cmode, 16'h1);
    for (int m = 3; m >= 0; m--) begin
      send({1'b1, IDX_SLOT, 3'b010}, {2'(m), 6'h04});
      chk(sync, 16'(m));
    end
    send({1'b1, IDX_GAIN, 3'b110}, 8'h00);
    chk({rv, rdata, pwr}, 16'h3e6);
    $display("register test done");
    @(posedge fs);
    repeat (20) @(negedge clk);
    send(8'h00, 8'hff);
    chk({pwr, oe}, 16'h2);
    for (int i = 0; i < 4; i++) begin
      send({1'b0, IDX_PATH, 3'b010}, pv[i]);
      chk({mic, mute, ears, exts}, 16'(pe[i]));
    end
    send({1'b0, IDX_PATH, 3'b010}, 8'h3f);
    {n, fsq, mq, txb} = '0;
    for (int k = 0; k < 2000 && oe !== 1'b1; k++) begin
      es = enc;
      @(negedge clk);
      n += 16'(fs && !fsq);
      fsq = fs;
    end
    chk({n[7:0], es, enc}, 16'ha);
    for (int k = 0; k < 400 && rxv !== 1'b1; k++) begin
      @(negedge clk);
      if (mq && !mclk && oe) txb = {txb[6:0], tx};
      mq = mclk;
    end
    chk(txb, 16'h3c);
    chk({rxv, rxw[7:0]}, 16'h1a5);
    $display("voice test done");
    send({1'b1, IDX_PATH, 3'b110}, 8'h00);
    chk({rv, rdata, pwr}, 16'h27e);
    n = '0;
    repeat (400) begin
      @(negedge clk);
      n += 16'({rxv, oe} != 2'b00);
    end
    chk(n, 16'h0);
    send(8'h00, 8'h00);
    run = 1'b0;
    repeat (300) @(negedge clk);
    chk({lost, pwr, oe}, 16'h4);
    $display("power test done");
    print_verdict;
  end
  initial begin
    #2000000;
    err_count++;
    print_verdict;
  end
endmodule
bind cpc_path_ctrl cpc_path_ctrl_assertions cpc_path_ctrl_assertions_inst (.*);
